//--- pkg/adc_compute_defines.svh
// Offsets, field positions, reset values and timing counts of the compute block.
// Assumes APB byte addressing with one register per aligned 32-bit word.
`ifndef ADC_COMPUTE_DEFINES_SVH
`define ADC_COMPUTE_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_MODE_CTRL 10'h113
`define IDX_ERR_THR 10'h114
`define IDX_STATUS 10'h115
`define IDX_CONV_CTRL 10'h120
`define IDX_SETPOINT 10'h121
`define IDX_UPPER 10'h122
`define IDX_LOWER 10'h123
`define IDX_REPEAT 10'h124
`define IDX_RESULT 10'h125
`define IDX_PREV 10'h126
`define IDX_FILTER 10'h127
`define IDX_ACCUM 10'h128
`define IDX_ERROR 10'h129
`define IDX_COUNT 10'h12a

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MODE_PREV_SOURCE_SEL 7
`define MODE_CRS_LSB 4
`define MODE_ACCUM_CLEAR_CMD 3
`define MODE_MD_LSB 0
`define ERR_ERROR_SEL_A_LSB 4
`define ERR_SOI 3
`define ERR_TMD_LSB 0
`define STAT_OV 7
`define STAT_ABOVE_UPPER_FLAG 6
`define STAT_BELOW_LOWER_FLAG 5
`define STAT_COMPUTE_UPDATED_FLAG 4
`define CC_GO 0
`define CC_CONTINUOUS_ENABLE 1
`define CC_DOUBLE_SAMPLE_ENABLE 2
`define CC_THR_FLAG 7

// ----------------------------------------------------------------------------
// Reset values and stage codes
// ----------------------------------------------------------------------------
`define RST_MODE_CTRL 8'h00
`define RST_ERR_THR 7'h00
`define STG_IDLE 3'h0
`define STG_CONV1 3'h1
`define STG_ERROR_SEL_A 3'h4
`define STG_CONV2 3'h7

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define CLR_TIME_NS 16
`define CLR_CYCLES ((`CLR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- pkg/adc_compute_pkg.sv
// Types shared by the compute block and its error stage.
// Assumes nothing beyond a SystemVerilog compiler.
package adc_compute_pkg;

  // --------------------------------------------------------------------------
  // Mode, error-select, threshold and state codes
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    MD_BASIC = 3'h0,
    MD_ACCUM = 3'h1,
    MD_AVG = 3'h2,
    MD_BURST = 3'h3,
    MD_LPF = 3'h4
  } compute_mode_e;

  typedef enum logic [2:0] {
    ERROR_SEL_A_DIFF = 3'h0,
    ERROR_SEL_A_SETPT = 3'h1,
    ERROR_SEL_A_FILT = 3'h2,
    ERROR_SEL_A_PREV_FILT = 3'h4,
    ERROR_SEL_A_FILT_SETPT = 3'h5
  } err_error_sel_a_e;

  typedef enum logic [2:0] {
    TMD_NEVER = 3'h0,
    TMD_BELOW = 3'h1,
    TMD_NOT_BELOW = 3'h2,
    TMD_INSIDE = 3'h3,
    TMD_OUTSIDE = 3'h4,
    TMD_NOT_ABOVE = 3'h5,
    TMD_ABOVE = 3'h6,
    TMD_ALWAYS = 3'h7
  } thr_mode_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CONV1 = 4'b0010,
    ST_CONV2 = 4'b0100,
    ST_ERROR_SEL_A = 4'b1000
  } conv_state_e;

endpackage

//--- pkg/error_sel_a_if.sv
// Operands and answers between the control block and its error stage.
// Assumes both ends run in one clock domain; the path is combinational.
`timescale 1ns/100ps
interface error_sel_a_if;
  import adc_compute_pkg::*;
  logic [15:0] result;
  logic [15:0] prev;
  logic [15:0] setpoint;
  logic [15:0] filter;
  logic signed [15:0] upper;
  logic signed [15:0] lower;
  logic [2:0] error_sel_a_sel;
  logic [2:0] thr_sel;
  logic double_sample_enable;
  logic signed [15:0] err;
  logic err_ovf;
  logic above;
  logic below;
  logic hit;
  modport ctrl (output result, prev, setpoint, filter, upper, lower, error_sel_a_sel, thr_sel,
    double_sample_enable, input err, err_ovf, above, below, hit);
  modport error_sel_a (input result, prev, setpoint, filter, upper, lower, error_sel_a_sel, thr_sel,
    double_sample_enable, output err, err_ovf, above, below, hit);
endinterface

//--- core/error_error_sel_a.sv
// Error value, overflow and threshold test of the compute block.
// Assumes registered operands from the control block; purely combinational.
`timescale 1ns/100ps
module error_error_sel_a
  import adc_compute_pkg::*;
(
  error_sel_a_if.error_sel_a c
);

  logic signed [17:0] d1;
  logic signed [17:0] e;
  logic signed [17:0] res_x;
  logic signed [17:0] prev_x;
  logic signed [17:0] sp_x;
  logic signed [17:0] flt_x;

  // --------------------------------------------------------------------------
  // Error formation
  // --------------------------------------------------------------------------
  always_comb begin
    res_x = $signed({2'b00, c.result});
    prev_x = $signed({2'b00, c.prev});
    sp_x = $signed({2'b00, c.setpoint});
    flt_x = $signed({2'b00, c.filter});
    d1 = res_x - prev_x;
    case (c.error_sel_a_sel)
      ERROR_SEL_A_DIFF: e = d1;
      ERROR_SEL_A_SETPT: e = c.double_sample_enable ? d1 - sp_x : res_x - sp_x;
      ERROR_SEL_A_FILT: e = c.double_sample_enable ? d1 - flt_x : res_x - flt_x;
      ERROR_SEL_A_PREV_FILT: e = prev_x - flt_x;
      ERROR_SEL_A_FILT_SETPT: e = flt_x - sp_x;
      default: e = 18'sh0;
    endcase
    c.err = e[15:0];
    c.err_ovf = (e[17:15] != 3'b000) && (e[17:15] != 3'b111);
  end

  // --------------------------------------------------------------------------
  // Threshold test
  // --------------------------------------------------------------------------
  always_comb begin
    c.above = c.err > c.upper;
    c.below = c.err < c.lower;
    case (c.thr_sel)
      TMD_NEVER: c.hit = 1'b0;
      TMD_BELOW: c.hit = c.below;
      TMD_NOT_BELOW: c.hit = !c.below;
      TMD_INSIDE: c.hit = (c.err > c.lower) && (c.err < c.upper);
      TMD_OUTSIDE: c.hit = c.below || c.above;
      TMD_NOT_ABOVE: c.hit = !c.above;
      TMD_ABOVE: c.hit = c.above;
      TMD_ALWAYS: c.hit = 1'b1;
      default: c.hit = 1'b0;
    endcase
  end

endmodule

//--- core/adc_compute_threshold_ctrl.sv
// Compute, threshold and retrigger control of a converter, with APB registers.
// Assumes the converter pulses conv_done with conv_data on pclk after conv_start.
`timescale 1ns/100ps
`include "adc_compute_defines.svh"
module adc_compute_threshold_ctrl
  import adc_compute_pkg::*;
#(
  parameter int DATA_W = 12,
  parameter int ACC_W = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [DATA_W-1:0] conv_data
);

  localparam logic [2:0] CLR_LOAD = 3'(`CLR_CYCLES);

  error_sel_a_if cif ();

  conv_state_e state_r, state_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [6:0] errthr_r, errthr_nxt;
  logic go_r, go_nxt;
  logic continuous_enable_r, continuous_enable_nxt;
  logic double_sample_enable_r, double_sample_enable_nxt;
  logic thr_flag_r, thr_flag_nxt;
  logic [15:0] setpt_r, setpt_nxt;
  logic [15:0] upper_r, upper_nxt;
  logic [15:0] lower_r, lower_nxt;
  logic [7:0] repeat_r, repeat_nxt;
  logic [15:0] result_r, result_nxt;
  logic [15:0] prev_r, prev_nxt;
  logic [15:0] filter_r, filter_nxt;
  logic [ACC_W-1:0] acc_r, acc_nxt;
  logic [15:0] err_r, err_nxt;
  logic [7:0] count_r, count_nxt;
  logic ov_r, ov_nxt;
  logic above_upper_flag_r, above_upper_flag_nxt;
  logic below_lower_flag_r, below_lower_flag_nxt;
  logic compute_updated_flag_r, compute_updated_flag_nxt;
  logic [2:0] clr_cnt_r, clr_cnt_nxt;
  logic conv_start_r, conv_start_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;

  logic [9:0] idx;
  logic access;
  logic wr_en;
  logic mapped;
  logic [31:0] rdata;
  logic [ACC_W:0] acc_sum;
  logic [ACC_W:0] acc_lp;
  logic [2:0] right_shift_sel;
  logic [2:0] md;
  logic [7:0] count_inc;
  logic tested;
  logic batch_done;
  logic acc_ovf;

  // --------------------------------------------------------------------------
  // Error stage
  // --------------------------------------------------------------------------
  assign cif.result = result_r;
  assign cif.prev = prev_r;
  assign cif.setpoint = setpt_r;
  assign cif.filter = filter_r;
  assign cif.upper = $signed(upper_r);
  assign cif.lower = $signed(lower_r);
  assign cif.error_sel_a_sel = errthr_r[`ERR_ERROR_SEL_A_LSB +: 3];
  assign cif.thr_sel = errthr_r[`ERR_TMD_LSB +: 3];
  assign cif.double_sample_enable = double_sample_enable_r;

  error_error_sel_a u_error_sel_a (
    .c(cif.error_sel_a)
  );

  // --------------------------------------------------------------------------
  // Register read mux
  // --------------------------------------------------------------------------
  always_comb begin
    idx = paddr[11:2];
    mapped = 1'b1;
    rdata = 32'h0;
    case (idx)
      `IDX_MODE_CTRL: rdata = 32'(mode_r);
      `IDX_ERR_THR: rdata = 32'(errthr_r);
      `IDX_STATUS: rdata = 32'({ov_r, above_upper_flag_r, below_lower_flag_r, compute_updated_flag_r, 1'b0,
        (state_r == ST_CONV1) ? `STG_CONV1 :
        (state_r == ST_CONV2) ? `STG_CONV2 :
        (state_r == ST_ERROR_SEL_A) ? `STG_ERROR_SEL_A : `STG_IDLE});
      `IDX_CONV_CTRL: rdata = 32'({thr_flag_r, 4'h0, double_sample_enable_r, continuous_enable_r, go_r});
      `IDX_SETPOINT: rdata = 32'(setpt_r);
      `IDX_UPPER: rdata = 32'(upper_r);
      `IDX_LOWER: rdata = 32'(lower_r);
      `IDX_REPEAT: rdata = 32'(repeat_r);
      `IDX_RESULT: rdata = 32'(result_r);
      `IDX_PREV: rdata = 32'(prev_r);
      `IDX_FILTER: rdata = 32'(filter_r);
      `IDX_ACCUM: rdata = 32'(acc_r);
      `IDX_ERROR: rdata = 32'(err_r);
      `IDX_COUNT: rdata = 32'(count_r);
      default: mapped = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    access = psel && penable && !pready_r;
    wr_en = psel && penable && pready_r && pwrite && mapped;
    md = mode_r[`MODE_MD_LSB +: 3];
    right_shift_sel = mode_r[`MODE_CRS_LSB +: 3];
    count_inc = (count_r == 8'hff) ? count_r : count_r + 8'h01;
    acc_sum = {1'b0, acc_r} + (ACC_W+1)'(result_r);
    acc_lp = acc_sum - (ACC_W+1)'(acc_r >> right_shift_sel);
    acc_ovf = 1'b0;
    tested = 1'b0;
    batch_done = 1'b0;

    state_nxt = state_r;
    mode_nxt = mode_r;
    errthr_nxt = errthr_r;
    go_nxt = go_r;
    continuous_enable_nxt = continuous_enable_r;
    double_sample_enable_nxt = double_sample_enable_r;
    thr_flag_nxt = thr_flag_r;
    setpt_nxt = setpt_r;
    upper_nxt = upper_r;
    lower_nxt = lower_r;
    repeat_nxt = repeat_r;
    result_nxt = result_r;
    prev_nxt = prev_r;
    filter_nxt = filter_r;
    acc_nxt = acc_r;
    err_nxt = err_r;
    count_nxt = count_r;
    ov_nxt = ov_r;
    above_upper_flag_nxt = above_upper_flag_r;
    below_lower_flag_nxt = below_lower_flag_r;
    compute_updated_flag_nxt = compute_updated_flag_r;
    clr_cnt_nxt = clr_cnt_r;
    conv_start_nxt = 1'b0;

    // APB answer one cycle into the access phase
    pready_nxt = access;
    pslverr_nxt = access && !mapped;
    prdata_nxt = (access && !pwrite) ? rdata : 32'h0;

    // Software writes
    if (wr_en) begin
      case (idx)
        `IDX_MODE_CTRL: begin
          mode_nxt = pwdata[7:0];
          mode_nxt[`MODE_ACCUM_CLEAR_CMD] = mode_r[`MODE_ACCUM_CLEAR_CMD] || pwdata[`MODE_ACCUM_CLEAR_CMD];
          if (pwdata[`MODE_ACCUM_CLEAR_CMD] && !mode_r[`MODE_ACCUM_CLEAR_CMD]) begin
            clr_cnt_nxt = CLR_LOAD;
          end
        end
        `IDX_ERR_THR: errthr_nxt = pwdata[6:0];
        `IDX_CONV_CTRL: begin
          continuous_enable_nxt = pwdata[`CC_CONTINUOUS_ENABLE];
          double_sample_enable_nxt = pwdata[`CC_DOUBLE_SAMPLE_ENABLE];
          if (pwdata[`CC_THR_FLAG]) begin
            thr_flag_nxt = 1'b0;
          end
        end
        `IDX_SETPOINT: setpt_nxt = pwdata[15:0];
        `IDX_UPPER: upper_nxt = pwdata[15:0];
        `IDX_LOWER: lower_nxt = pwdata[15:0];
        `IDX_REPEAT: repeat_nxt = pwdata[7:0];
        default: ;
      endcase
    end

    // Conversion sequence
    case (state_r)
      ST_IDLE: begin
        if (go_r) begin
          prev_nxt = mode_r[`MODE_PREV_SOURCE_SEL] ? filter_r : result_r;
          compute_updated_flag_nxt = 1'b0;
          conv_start_nxt = 1'b1;
          state_nxt = ST_CONV1;
        end
      end
      ST_CONV1: begin
        if (conv_done) begin
          if (double_sample_enable_r) begin
            prev_nxt = 16'(conv_data);
            conv_start_nxt = 1'b1;
            state_nxt = ST_CONV2;
          end else begin
            result_nxt = 16'(conv_data);
            state_nxt = ST_ERROR_SEL_A;
          end
        end
      end
      ST_CONV2: begin
        if (conv_done) begin
          result_nxt = 16'(conv_data);
          state_nxt = ST_ERROR_SEL_A;
        end
      end
      ST_ERROR_SEL_A: begin
        state_nxt = ST_IDLE;
        case (md)
          MD_BASIC: tested = 1'b1;
          MD_ACCUM: begin
            acc_nxt = acc_sum[ACC_W-1:0];
            acc_ovf = acc_sum[ACC_W];
            count_nxt = count_inc;
            tested = 1'b1;
          end
          MD_AVG, MD_BURST: begin
            if (count_r >= repeat_r) begin
              acc_nxt = ACC_W'(result_r);
              count_nxt = 8'h01;
            end else begin
              acc_nxt = acc_sum[ACC_W-1:0];
              acc_ovf = acc_sum[ACC_W];
              count_nxt = count_inc;
            end
            batch_done = count_nxt >= repeat_r;
            if (batch_done) begin
              filter_nxt = 16'(acc_nxt >> right_shift_sel);
              tested = 1'b1;
            end
          end
          MD_LPF: begin
            acc_nxt = acc_lp[ACC_W-1:0];
            acc_ovf = acc_lp[ACC_W];
            filter_nxt = 16'(acc_lp[ACC_W-1:0] >> right_shift_sel);
            count_nxt = count_inc;
            tested = 1'b1;
          end
          default: tested = 1'b0;
        endcase
        if (md != MD_BASIC) begin
          compute_updated_flag_nxt = 1'b1;
        end
        if (acc_ovf) begin
          ov_nxt = 1'b1;
        end
        if (tested) begin
          err_nxt = cif.err;
          above_upper_flag_nxt = cif.above;
          below_lower_flag_nxt = cif.below;
          compute_updated_flag_nxt = 1'b1;
          if (cif.err_ovf) begin
            ov_nxt = 1'b1;
          end
          if (cif.hit) begin
            thr_flag_nxt = 1'b1;
          end
        end
        // Burst keeps converting until its batch is complete
        if (md == MD_BURST && !batch_done) begin
          go_nxt = go_r;
        end else if (!continuous_enable_r) begin
          go_nxt = 1'b0;
        end else if (errthr_r[`ERR_SOI] && tested && cif.hit) begin
          go_nxt = 1'b0;
        end else begin
          go_nxt = go_r;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase

    // Software start and stop override hardware on the start bit
    if (wr_en && idx == `IDX_CONV_CTRL) begin
      go_nxt = pwdata[`CC_GO];
      if (!pwdata[`CC_GO] && state_r != ST_IDLE) begin
        state_nxt = ST_IDLE;
      end
    end

    // Accumulator clear sequence
    if (mode_r[`MODE_ACCUM_CLEAR_CMD]) begin
      if (clr_cnt_r > 3'h1) begin
        clr_cnt_nxt = clr_cnt_r - 3'h1;
      end else begin
        acc_nxt = '0;
        ov_nxt = tested && cif.err_ovf;
        count_nxt = 8'h00;
        compute_updated_flag_nxt = 1'b1;
        clr_cnt_nxt = 3'h0;
        mode_nxt[`MODE_ACCUM_CLEAR_CMD] = 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      mode_r <= `RST_MODE_CTRL;
      errthr_r <= `RST_ERR_THR;
      go_r <= 1'b0;
      continuous_enable_r <= 1'b0;
      double_sample_enable_r <= 1'b0;
      thr_flag_r <= 1'b0;
      setpt_r <= 16'h0;
      upper_r <= 16'h0;
      lower_r <= 16'h0;
      repeat_r <= 8'h0;
      result_r <= 16'h0;
      prev_r <= 16'h0;
      filter_r <= 16'h0;
      acc_r <= '0;
      err_r <= 16'h0;
      count_r <= 8'h0;
      ov_r <= 1'b0;
      above_upper_flag_r <= 1'b0;
      below_lower_flag_r <= 1'b0;
      compute_updated_flag_r <= 1'b0;
      clr_cnt_r <= 3'h0;
      conv_start_r <= 1'b0;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      errthr_r <= errthr_nxt;
      go_r <= go_nxt;
      continuous_enable_r <= continuous_enable_nxt;
      double_sample_enable_r <= double_sample_enable_nxt;
      thr_flag_r <= thr_flag_nxt;
      setpt_r <= setpt_nxt;
      upper_r <= upper_nxt;
      lower_r <= lower_nxt;
      repeat_r <= repeat_nxt;
      result_r <= result_nxt;
      prev_r <= prev_nxt;
      filter_r <= filter_nxt;
      acc_r <= acc_nxt;
      err_r <= err_nxt;
      count_r <= count_nxt;
      ov_r <= ov_nxt;
      above_upper_flag_r <= above_upper_flag_nxt;
      below_lower_flag_r <= below_lower_flag_nxt;
      compute_updated_flag_r <= compute_updated_flag_nxt;
      clr_cnt_r <= clr_cnt_nxt;
      conv_start_r <= conv_start_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign conv_start = conv_start_r;

endmodule

//--- verif/adc_compute_checker.sv
// Port-level assertions of the compute block.
// Assumes APB timing of the hand-over; bound to the top module below.
`timescale 1ns/100ps
`include "adc_compute_defines.svh"
module adc_compute_checker #(
  parameter int DATA_W = 12,
  parameter int ACC_W = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic [DATA_W-1:0] conv_data
);
  // ------------------------------
  // Shadow of written fields
  // ------------------------------
  logic wr;
  logic rd;
  logic [9:0] ix;
  logic [7:0] mode_r;
  logic [7:0] thr_r;
  logic double_sample_enable_r;
  logic keep_r;
  logic [2:0] age_r;
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && pready && !pwrite;
  assign ix = paddr[11:2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= 8'h00;
      thr_r <= 8'h00;
      double_sample_enable_r <= 1'b0;
      keep_r <= 1'b0;
      age_r <= 3'h7;
    end else begin
      if (wr && ix == `IDX_MODE_CTRL) begin
        mode_r <= pwdata[7:0];
      end
      if (wr && ix == `IDX_ERR_THR) begin
        thr_r <= pwdata[7:0];
      end
      if (wr && ix == `IDX_CONV_CTRL) begin
        double_sample_enable_r <= pwdata[2];
        keep_r <= pwdata[0] && pwdata[1] && !thr_r[3];
      end else if (wr && ix == `IDX_ERR_THR && pwdata[3]) begin
        keep_r <= 1'b0;
      end
      if (wr && ix == `IDX_MODE_CTRL && pwdata[3]) begin
        age_r <= 3'h0;
      end else if (age_r != 3'h7) begin
        age_r <= age_r + 3'h1;
      end
    end
  end
  // ------------------------------
  // Assertions
  // ------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ACCUM_CLEAR_CMD_HOLD: assert property (wr && ix == `IDX_MODE_CTRL && pwdata[3] |->
    ##4 (!(rd && ix == `IDX_MODE_CTRL) || prdata[3])) else $error("clear ended early");
  AST_ACCUM_CLEAR_CMD_DONE: assert property (rd && ix == `IDX_MODE_CTRL && age_r == 3'h7 |->
    !prdata[3]) else $error("clear never ended");
  AST_MODE_RD: assert property (rd && ix == `IDX_MODE_CTRL |-> prdata[31:8] == 0 &&
    prdata[7:4] == mode_r[7:4] && prdata[2:0] == mode_r[2:0]) else $error("mode readback");
  AST_THR_RD: assert property (rd && ix == `IDX_ERR_THR |-> prdata[31:7] == 0 &&
    prdata[6:4] == thr_r[6:4] && prdata[2:0] == thr_r[2:0]) else $error("thr readback");
  AST_STAT_RSVD: assert property (rd && ix == `IDX_STATUS |->
    prdata[31:8] == 0 && !prdata[3]) else $error("status spare bits set");
  AST_START_PULSE: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  AST_STAGE2: assert property (rd && ix == `IDX_STATUS && prdata[2:0] == 3'h7 |->
    double_sample_enable_r) else $error("second stage without double sample");
  AST_GO_KEPT: assert property (rd && ix == `IDX_CONV_CTRL && keep_r |->
    prdata[0]) else $error("start bit cleared by hardware");
endmodule
bind adc_compute_threshold_ctrl adc_compute_checker #(.DATA_W(DATA_W), .ACC_W(ACC_W)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data));

//--- verif/tb.sv
// Self-checking bench of the compute block against a behavioural model.
// Assumes the package and defines header are compiled first.
`timescale 1ns/100ps
`include "adc_compute_defines.svh"
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic conv_done = 1'b0;
  logic [11:0] conv_data = 12'h000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic conv_start;
  logic [31:0] rdat;
  logic rerr;
  logic [7:0] mv;
  int num_errors = 0;
  int samples_checked = 0;
  int res_m = 0;
  int prev_m = 0;
  int nst, e, up, lo, sp, d1, d2, threshold_irq_sel, error_sel_a;
  bit ds, prev_source_sel, hit;
  adc_compute_threshold_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_start(conv_start), .conv_done(conv_done),
    .conv_data(conv_data));
  // ------------------------------
  // Tasks and model
  // ------------------------------
  initial begin
    forever #2 pclk = ~pclk;
  end
  task automatic close_out();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input bit w, input logic [9:0] ix, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [9:0] ix, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, ix, 32'h0);
    chk(rdat & m, x & m);
  endtask
  task automatic cnt(input int k);
    nst = 0;
    repeat (k) begin
      @(posedge pclk);
      nst += (conv_start === 1'b1);
    end
  endtask
  task automatic wstart();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (conv_start !== 1'b1 && n < 100);
    chk(32'(conv_start), 32'h1);
  endtask
  task automatic give(input int d);
    conv_done <= 1'b1;
    conv_data <= 12'(d);
    @(posedge pclk);
    conv_done <= 1'b0;
    conv_data <= 12'($urandom);
  endtask
  task automatic conv(input logic [7:0] ctl, input int a, input int b);
    apb(1'b1, `IDX_CONV_CTRL, {24'h0, ctl});
    prev_m = prev_source_sel ? 0 : res_m;
    wstart();
    give(a);
    res_m = a;
    if (ctl[2]) begin
      prev_m = a;
      wstart();
      rc(`IDX_STATUS, 32'h7, 32'h7);
      give(b);
      res_m = b;
    end
  endtask
  function automatic int err_of(int c, bit s2);
    int r;
    r = s2 ? res_m - prev_m : res_m;
    case (c)
      0: return res_m - prev_m;
      1: return r - sp;
      2: return r;
      4: return prev_m;
      5: return -sp;
      default: return 0;
    endcase
  endfunction
  function automatic bit hit_of(int t);
    case (t)
      0: return 0;
      1: return e < lo;
      2: return e >= lo;
      3: return e > lo && e < up;
      4: return e < lo || e > up;
      5: return e <= up;
      6: return e > up;
      default: return 1;
    endcase
  endfunction
  // ------------------------------
  // Tests
  // ------------------------------
  initial begin
    void'($urandom(32'h2f67));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rc(`IDX_MODE_CTRL, 32'hffffffff, 32'h0);
    rc(`IDX_ERR_THR, 32'hffffffff, 32'h0);
    apb(1'b1, `IDX_STATUS, 32'hffffffff);
    rc(`IDX_STATUS, 32'hffffffff, 32'h0);
    apb(1'b0, 10'h200, 32'h0);
    chk(rdat, 32'h0);
    chk(32'(rerr), 32'h1);
    for (int i = 0; i < 16; i++) begin
      error_sel_a = i % 8;
      threshold_irq_sel = (i * 3) % 8;
      prev_source_sel = $urandom % 2;
      ds = (i % 3 == 0);
      sp = $urandom % 2048;
      up = $urandom % 8192 - 4096;
      lo = $urandom % 8192 - 4096;
      d1 = $urandom % 4096;
      d2 = $urandom % 4096;
      mv = {prev_source_sel, 3'($urandom), 4'h0};
      apb(1'b1, `IDX_MODE_CTRL, {24'h0, mv});
      rc(`IDX_MODE_CTRL, 32'hff, {24'h0, mv});
      apb(1'b1, `IDX_ERR_THR, {25'h0, 3'(error_sel_a), 1'($urandom), 3'(threshold_irq_sel)});
      apb(1'b1, `IDX_SETPOINT, 32'(sp));
      apb(1'b1, `IDX_UPPER, {16'h0, 16'(up)});
      apb(1'b1, `IDX_LOWER, {16'h0, 16'(lo)});
      conv({5'h0, ds, 2'b01}, d1, d2);
      repeat (3) @(posedge pclk);
      e = err_of(error_sel_a, ds);
      hit = hit_of(threshold_irq_sel);
      rc(`IDX_ERROR, 32'hffff, 32'(e));
      rc(`IDX_STATUS, 32'he7, {24'h0, 1'b0, e > up, e < lo, 5'h0});
      rc(`IDX_CONV_CTRL, 32'h81, {24'h0, hit, 7'h0});
      rc(`IDX_PREV, 32'hfff, 32'(prev_m));
      apb(1'b1, `IDX_CONV_CTRL, 32'h80);
    end
    prev_source_sel = 1'b0;
    apb(1'b1, `IDX_MODE_CTRL, 32'h09);
    rc(`IDX_MODE_CTRL, 32'h08, 32'h08);
    repeat (8) @(posedge pclk);
    rc(`IDX_MODE_CTRL, 32'h0f, 32'h01);
    conv(8'h01, d1, 0);
    conv(8'h01, d2, 0);
    repeat (3) @(posedge pclk);
    rc(`IDX_ACCUM, 32'h3ffff, 32'(d1 + d2));
    rc(`IDX_COUNT, 32'hff, 32'h2);
    rc(`IDX_STATUS, 32'h10, 32'h10);
    apb(1'b1, `IDX_MODE_CTRL, 32'h09);
    repeat (8) @(posedge pclk);
    rc(`IDX_ACCUM, 32'hffffffff, 32'h0);
    rc(`IDX_COUNT, 32'hffffffff, 32'h0);
    rc(`IDX_STATUS, 32'h80, 32'h0);
    apb(1'b1, `IDX_ERR_THR, 32'h0f);
    conv(8'h03, d1, 0);
    cnt(12);
    chk(32'(nst), 32'h0);
    rc(`IDX_CONV_CTRL, 32'h01, 32'h0);
    apb(1'b1, `IDX_ERR_THR, 32'h07);
    conv(8'h03, d2, 0);
    cnt(12);
    chk(32'(nst), 32'h1);
    rc(`IDX_CONV_CTRL, 32'h01, 32'h1);
    apb(1'b1, `IDX_CONV_CTRL, 32'h0);
    cnt(12);
    chk(32'(nst), 32'h0);
    apb(1'b1, `IDX_REPEAT, 32'h2);
    apb(1'b1, `IDX_MODE_CTRL, 32'h1a);
    repeat (8) @(posedge pclk);
    conv(8'h01, d1, 0);
    conv(8'h01, d2, 0);
    repeat (3) @(posedge pclk);
    rc(`IDX_FILTER, 32'hffff, 32'((d1 + d2) >> 1));
    rc(`IDX_COUNT, 32'hff, 32'h2);
    apb(1'b1, `IDX_MODE_CTRL, 32'h1b);
    repeat (8) @(posedge pclk);
    conv(8'h01, d2, 0);
    wstart();
    give(d1);
    repeat (3) @(posedge pclk);
    rc(`IDX_FILTER, 32'hffff, 32'((d1 + d2) >> 1));
    rc(`IDX_CONV_CTRL, 32'h01, 32'h0);
    apb(1'b1, `IDX_MODE_CTRL, 32'h1c);
    repeat (8) @(posedge pclk);
    conv(8'h01, d1, 0);
    conv(8'h01, d2, 0);
    repeat (3) @(posedge pclk);
    rc(`IDX_ACCUM, 32'h3ffff, 32'(d1 + d2 - (d1 >> 1)));
    rc(`IDX_FILTER, 32'hffff, 32'((d1 + d2 - (d1 >> 1)) >> 1));
    apb(1'b1, `IDX_SETPOINT, 32'hffff);
    apb(1'b1, `IDX_ERR_THR, 32'h10);
    conv(8'h01, d1, 0);
    repeat (3) @(posedge pclk);
    rc(`IDX_STATUS, 32'h80, 32'h80);
    close_out();
  end
  initial begin
    repeat (10000) @(posedge pclk);
    num_errors++;
    close_out();
  end
endmodule
